// *** rtl/pwm_gate_pkg.sv ***
// constants shared by the pwm gate timing engine: register map, field layout,
// reset values, chopper mode codes and timing figures.
// assumes a 32-bit classic wishbone slave with byte addressing.
package pwm_gate_pkg;

  // ****************************************
  // register map (word index, byte address = 4 * index)
  // ****************************************
  localparam logic [7:0]  IDX_POLARITY   = 8'h17;
  localparam logic [7:0]  IDX_PERIOD     = 8'h18;
  localparam logic [7:0]  IDX_DEAD_TIME  = 8'h19;
  localparam logic [7:0]  IDX_CHOP       = 8'h1a;
  localparam logic [7:0]  IDX_STATUS     = 8'h1d;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          SEL_W          = 4;

  // ****************************************
  // field layout
  // ****************************************
  localparam int          POL_LOW_BIT    = 0;
  localparam int          POL_HIGH_BIT   = 1;
  localparam int          POL_W          = 2;
  localparam int          CNT_W          = 12;
  localparam int          DEAD_W         = 8;
  localparam int          DEAD_LOW_LSB   = 0;
  localparam int          DEAD_HIGH_LSB  = 8;
  localparam int          CHOP_W         = 9;
  localparam int          MODE_W         = 8;
  localparam int          SV_BIT         = 8;
  localparam int          STAT_LOW_LSB   = 16;
  localparam int          STAT_HIGH_LSB  = 24;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [POL_W-1:0]  RST_POLARITY  = 2'h3;
  localparam logic [CNT_W-1:0]  RST_PERIOD    = 12'hf9f;
  localparam logic [15:0]       RST_DEAD_TIME = 16'h1414;
  localparam logic [CHOP_W-1:0] RST_CHOP      = 9'h000;

  // ****************************************
  // chopper mode codes
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_LOW_ON    = 8'h01;
  localparam logic [MODE_W-1:0] MODE_HIGH_ON   = 8'h02;
  localparam logic [MODE_W-1:0] MODE_LOW_CHOP  = 8'h05;
  localparam logic [MODE_W-1:0] MODE_HIGH_CHOP = 8'h06;
  localparam logic [MODE_W-1:0] MODE_CENTERED  = 8'h07;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          DEAD_UNIT_NS   = 10;

endpackage : pwm_gate_pkg

// *** rtl/pwm_gate_timing_engine.sv ***
// pwm gate timing engine: period counter, chopper modes, centered pwm with
// optional space vector offset, break-before-make delays and gate polarity.
// assumes duty words come from logic on clock_i and a wishbone master.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
module pwm_gate_timing_engine
  import pwm_gate_pkg::*;
#(
  parameter int PHASES = 3
)(
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ADDR_W-1:0]       wb_adr_i,
  input  wire logic [SEL_W-1:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0]       wb_dat_i,
  output logic      [DATA_W-1:0]       wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [PHASES*CNT_W-1:0] duty_i,
  output logic      [PHASES-1:0]       gate_low_o,
  output logic      [PHASES-1:0]       gate_high_o,
  output logic                         period_start_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [SEL_W-1:0]  sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < SEL_W; b++)
      if (sel[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction : merge

  // dead time rounded up to whole clock cycles
  function automatic logic [DEAD_W-1:0] dead_cycles(input logic [DEAD_W-1:0] v);
    logic [11:0] t;
    t = {4'h0, v} * 12'(DEAD_UNIT_NS) + 12'(CLK_PERIOD_NS - 1);
    return DEAD_W'(t / 12'(CLK_PERIOD_NS));
  endfunction : dead_cycles

  // on-window symmetric about the middle of the period
  function automatic logic centered_on(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] maxc,
                                       input logic [CNT_W-1:0] duty);
    logic [CNT_W:0] span;
    logic [CNT_W:0] d;
    logic [CNT_W:0] lo;
    span = {1'b0, maxc} + (CNT_W+1)'(1);
    d    = ({1'b0, duty} > span) ? span : {1'b0, duty};
    lo   = (span - d) >> 1;
    return ({1'b0, cnt} >= lo) && ({1'b0, cnt} < lo + d);
  endfunction : centered_on

  // ****************************************
  // register bus
  // ****************************************
  logic [POL_W-1:0]  pol_q;
  logic [CNT_W-1:0]  maxcnt_q;
  logic [15:0]       dead_q;
  logic [CHOP_W-1:0] chop_q;
  logic              ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [PHASES-1:0] low_q;
  logic [PHASES-1:0] high_q;

  wire               req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire               wr       = req & wb_we_i;
  wire [ADDR_W-1:0]  a_pol    = ADDR_W'({IDX_POLARITY, 2'b00});
  wire [ADDR_W-1:0]  a_per    = ADDR_W'({IDX_PERIOD, 2'b00});
  wire [ADDR_W-1:0]  a_dead   = ADDR_W'({IDX_DEAD_TIME, 2'b00});
  wire [ADDR_W-1:0]  a_chop   = ADDR_W'({IDX_CHOP, 2'b00});
  wire [ADDR_W-1:0]  a_stat   = ADDR_W'({IDX_STATUS, 2'b00});
  wire               hit_pol  = wb_adr_i == a_pol;
  wire               hit_per  = wb_adr_i == a_per;
  wire               hit_dead = wb_adr_i == a_dead;
  wire               hit_chop = wb_adr_i == a_chop;
  wire               hit_stat = wb_adr_i == a_stat;

  wire [DATA_W-1:0]  rd_pol   = {{(DATA_W-POL_W){1'b0}}, pol_q};
  wire [DATA_W-1:0]  rd_per   = {{(DATA_W-CNT_W){1'b0}}, maxcnt_q};
  wire [DATA_W-1:0]  rd_dead  = {16'h0000, dead_q};
  wire [DATA_W-1:0]  rd_chop  = {{(DATA_W-CHOP_W){1'b0}}, chop_q};
  wire [DATA_W-1:0]  rd_stat  = DATA_W'({CNT_W'(cnt_q)})
                              | (DATA_W'(low_q) << STAT_LOW_LSB)
                              | (DATA_W'(high_q) << STAT_HIGH_LSB);

  wire [DATA_W-1:0]  wm_pol   = merge(rd_pol, wb_dat_i, wb_sel_i);
  wire [DATA_W-1:0]  wm_per   = merge(rd_per, wb_dat_i, wb_sel_i);
  wire [DATA_W-1:0]  wm_dead  = merge(rd_dead, wb_dat_i, wb_sel_i);
  wire [DATA_W-1:0]  wm_chop  = merge(rd_chop, wb_dat_i, wb_sel_i);

  // unmapped addresses read zero and ignore writes
  wire [DATA_W-1:0]  rdata_d  = hit_pol  ? rd_pol  :
                                hit_per  ? rd_per  :
                                hit_dead ? rd_dead :
                                hit_chop ? rd_chop :
                                hit_stat ? rd_stat : '0;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q    <= 1'b0;
      rdata_q  <= '0;
      pol_q    <= RST_POLARITY;
      maxcnt_q <= RST_PERIOD;
      dead_q   <= RST_DEAD_TIME;
      chop_q   <= RST_CHOP;
    end
    else
    begin
      ack_q   <= req;
      rdata_q <= req ? rdata_d : '0;
      if (wr && hit_pol)
        pol_q <= wm_pol[POL_W-1:0];
      if (wr && hit_per)
        maxcnt_q <= wm_per[CNT_W-1:0];
      if (wr && hit_dead)
        dead_q <= wm_dead[15:0];
      if (wr && hit_chop)
        chop_q <= wm_chop[CHOP_W-1:0];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ****************************************
  // period counter
  // ****************************************
  // wrap on >= so a smaller period written mid-cycle takes effect at once
  wire               wrap  = cnt_q >= maxcnt_q;
  wire [CNT_W-1:0]   cnt_d = wrap ? '0 : cnt_q + CNT_W'(1);
  logic              start_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q   <= '0;
      start_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      start_q <= wrap;
    end
  end

  assign period_start_o = start_q;

  // ****************************************
  // space vector offset
  // ****************************************
  wire [MODE_W-1:0]  mode   = chop_q[MODE_W-1:0];
  wire               sv_en  = chop_q[SV_BIT];
  logic [CNT_W-1:0]  dmax;
  logic [CNT_W-1:0]  dmin;

  always_comb
  begin
    dmax = '0;
    dmin = '1;
    for (int p = 0; p < PHASES; p++)
    begin
      if (duty_i[p*CNT_W +: CNT_W] > dmax)
        dmax = duty_i[p*CNT_W +: CNT_W];
      if (duty_i[p*CNT_W +: CNT_W] < dmin)
        dmin = duty_i[p*CNT_W +: CNT_W];
    end
  end

  // common-mode shift centres the duty envelope in the period
  wire signed [CNT_W+1:0] sv_shift = $signed({2'b00, maxcnt_q >> 1})
                                   - $signed({1'b0, ({1'b0, dmax} + {1'b0, dmin}) >> 1});

  wire [DEAD_W-1:0]  dl_cyc = dead_cycles(dead_q[DEAD_LOW_LSB +: DEAD_W]);
  wire [DEAD_W-1:0]  dh_cyc = dead_cycles(dead_q[DEAD_HIGH_LSB +: DEAD_W]);

  // ****************************************
  // per-phase gate logic
  // ****************************************
  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    wire [CNT_W-1:0]        duty_raw = duty_i[p*CNT_W +: CNT_W];
    wire signed [CNT_W+1:0] sum      = $signed({2'b00, duty_raw}) + sv_shift;
    wire [CNT_W-1:0]        duty_sv  = (sum < 0) ? '0 :
                                       (sum > $signed({2'b00, maxcnt_q})) ? maxcnt_q :
                                       sum[CNT_W-1:0];
    wire [CNT_W-1:0]        duty_use = sv_en ? duty_sv : duty_raw;
    wire                    pwm_on   = centered_on(cnt_q, maxcnt_q, duty_use);

    // requested gate states per chopper mode, others leave both off
    wire low_req  = (mode == MODE_LOW_ON)   ||
                    ((mode == MODE_LOW_CHOP) && pwm_on) ||
                    ((mode == MODE_CENTERED) && !pwm_on);
    wire high_req = (mode == MODE_HIGH_ON)  ||
                    ((mode == MODE_HIGH_CHOP) && pwm_on) ||
                    ((mode == MODE_CENTERED) && pwm_on);

    logic [DEAD_W-1:0] high_off_q;
    logic [DEAD_W-1:0] low_off_q;

    // an opposite side must have been off for the full dead time
    wire low_d  = low_req  && !high_q[p] && !high_req && (high_off_q >= dl_cyc);
    wire high_d = high_req && !low_q[p]  && !low_req  && (low_off_q  >= dh_cyc);

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        low_q[p]    <= 1'b0;
        high_q[p]   <= 1'b0;
        high_off_q  <= '0;
        low_off_q   <= '0;
        gate_low_o[p]  <= ~RST_POLARITY[POL_LOW_BIT];
        gate_high_o[p] <= ~RST_POLARITY[POL_HIGH_BIT];
      end
      else
      begin
        low_q[p]   <= low_d;
        high_q[p]  <= high_d;
        high_off_q <= high_q[p] ? '0 : ((&high_off_q) ? high_off_q : high_off_q + DEAD_W'(1));
        low_off_q  <= low_q[p]  ? '0 : ((&low_off_q)  ? low_off_q  : low_off_q  + DEAD_W'(1));
        gate_low_o[p]  <= ~(low_d ^ pol_q[POL_LOW_BIT]);
        gate_high_o[p] <= ~(high_d ^ pol_q[POL_HIGH_BIT]);
      end
    end
  end

endmodule : pwm_gate_timing_engine

// *** bench/gate_driver_model.sv ***
// half-bridge driver model: turns gate pins into switch conduction and
// counts cycles where both switches of one leg conduct.
// assumes the bench feeds the polarity it last wrote.
`timescale 1ns/1ns
module gate_driver_model #(
  parameter int PHASES = 3
)(
  input  wire logic              clock_i,
  input  wire logic [1:0]        pol_i,
  input  wire logic [PHASES-1:0] gate_low_i,
  input  wire logic [PHASES-1:0] gate_high_i,
  output int                     shoot_o
);
  wire [PHASES-1:0] low_on  = gate_low_i ~^ {PHASES{pol_i[0]}};
  wire [PHASES-1:0] high_on = gate_high_i ~^ {PHASES{pol_i[1]}};
  int count_q = 0;
  // sampled mid-cycle so pin updates at the edge have landed
  always @(negedge clock_i)
    if ((low_on & high_on) != '0)
      count_q <= count_q + 1;
  assign shoot_o = count_q;
endmodule : gate_driver_model

// *** bench/pwm_gate_properties.sv ***
// port checker for the gate timing engine, bound to its top module.
// assumes polarity changes only through bus writes seen at the ports.
`timescale 1ns/1ns
module pwm_gate_properties
  import pwm_gate_pkg::*;
#(
  parameter int PHASES = 3
)(
  input wire logic                    clock_i,
  input wire logic                    rst_n_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [ADDR_W-1:0]       wb_adr_i,
  input wire logic [SEL_W-1:0]        wb_sel_i,
  input wire logic [DATA_W-1:0]       wb_dat_i,
  input wire logic [DATA_W-1:0]       wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic [PHASES*CNT_W-1:0] duty_i,
  input wire logic [PHASES-1:0]       gate_low_o,
  input wire logic [PHASES-1:0]       gate_high_o,
  input wire logic                    period_start_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] pol_q;
  logic [2:0] age_q;
  wire pol_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h5c && wb_sel_i[0];
  // gate relations are judged only once pins have settled to a new polarity
  wire quiet = age_q == 3'h7;
  wire [PHASES-1:0] lo_on = gate_low_o ~^ {PHASES{pol_q[0]}};
  wire [PHASES-1:0] hi_on = gate_high_o ~^ {PHASES{pol_q[1]}};
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i) pol_q <= RST_POLARITY;
    else if (pol_wr) pol_q <= wb_dat_i[1:0];
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i) age_q <= 3'h7;
    else if (pol_wr) age_q <= 3'h0;
    else if (!quiet) age_q <= age_q + 3'h1;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_pol;
    s_req ##0 (!wb_we_i && wb_adr_i == 8'h5c);
  endsequence
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_answer; s_req |=> wb_ack_o; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
  property p_rd_pol; s_rd_pol |=> wb_dat_o == {30'h0, pol_q}; endproperty
  property p_no_overlap; quiet |-> (lo_on & hi_on) == '0; endproperty
  property p_low_break; quiet |-> (lo_on & ~$past(lo_on) & $past(hi_on)) == '0; endproperty
  property p_high_break; quiet |-> (hi_on & ~$past(hi_on) & $past(lo_on)) == '0; endproperty
  property p_start_pulse; period_start_o |=> !period_start_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  a_rd_pol: assert property (p_rd_pol) else $error("polarity read back wrong");
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
  a_low_break: assert property (p_low_break) else $error("low on without break");
  a_high_break: assert property (p_high_break) else $error("high on without break");
  a_start_pulse: assert property (p_start_pulse) else $error("period start too long");
endmodule : pwm_gate_properties
bind pwm_gate_timing_engine pwm_gate_properties #(.PHASES(PHASES)) u_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .duty_i(duty_i), .gate_low_o(gate_low_o),
  .gate_high_o(gate_high_o), .period_start_o(period_start_o));

// *** bench/tb.sv ***
// register-level bench for the gate timing engine with a driver model.
// assumes one 25 MHz clock and a single-cycle answering wishbone slave.
`timescale 1ns/1ns
module tb;
  import pwm_gate_pkg::*;
  logic clock_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, ack, pstart;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [35:0] duty = 36'h004004004;
  logic [2:0] gl, gh;
  logic [1:0] pol = 2'h3;
  logic [7:0] adrs [5] = '{8'h5c, 8'h60, 8'h64, 8'h68, 8'h70};
  logic [31:0] exps [5] = '{32'h3, 32'hf9f, 32'h1414, 32'h0, 32'h0};
  logic [7:0] offs [5] = '{8'h0, 8'h3, 8'h4, 8'h5, 8'h6};
  int fails = 0, check_count = 0, cycles = 0, n, s0, shoot;
  pwm_gate_timing_engine #(.PHASES(3)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .duty_i(duty), .gate_low_o(gl),
    .gate_high_o(gh), .period_start_o(pstart));
  gate_driver_model #(.PHASES(3)) u_drv (.clock_i(clock_i), .pol_i(pol), .gate_low_i(gl),
    .gate_high_i(gh), .shoot_o(shoot));
  initial forever #20 clock_i = ~clock_i;
  task conclude;
    $display("mismatches %0d, comparisons %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // a limit far above the few hundred cycles the sequence needs
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end
  task check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task wb_io(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    // ack and read data are taken at the rising edge that samples ack high
    do @(posedge clock_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
  endtask : wb_io
  // cycles from the opposite gate going off to this gate coming on
  task gap(output int k, input bit to_low);
    k = 0;
    do @(negedge clock_i); while ((to_low ? gh[0] : gl[0]) !== 1'b0);
    do
    begin
      @(negedge clock_i);
      k++;
    end
    while ((to_low ? gl[0] : gh[0]) !== 1'b1);
  endtask : gap
  // high-side on cycles of phase 0 over one ten-cycle period
  task width(output int k);
    k = 0;
    repeat (10)
    begin
      @(negedge clock_i);
      if (gh[0] === 1'b1)
        k++;
    end
  endtask : width
  task mode(input logic [7:0] m, input logic [5:0] e);
    wb_io(8'h68, 1'b1, {24'h0, m}, 4'hf);
    repeat (10) @(posedge clock_i);
    check({26'h0, gl, gh}, {26'h0, e});
  endtask : mode
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wb_io(adrs[i], 1'b0, 32'h0, 4'hf);
      check(rd, exps[i]);
    end
    wb_io(8'h64, 1'b1, 32'h0814, 4'hf);
    mode(8'h02, 6'b000111);
    fork
      gap(n, 1'b1);
      mode(8'h01, 6'b111000);
    join
    check(32'(n >= 5), 32'h1);
    fork
      gap(n, 1'b0);
      mode(8'h02, 6'b000111);
    join
    check(32'(n >= 2), 32'h1);
    for (int i = 0; i < 3; i++)
      mode(offs[i], 6'b000000);
    wb_io(8'h5c, 1'b1, 32'h0, 4'hf);
    pol = 2'h0;
    mode(8'h02, 6'b111000);
    wb_io(8'h5c, 1'b1, 32'h1, 4'hf);
    pol = 2'h1;
    mode(8'h02, 6'b000000);
    wb_io(8'h5c, 1'b1, 32'h3, 4'hf);
    pol = 2'h3;
    wb_io(8'h60, 1'b1, 32'h9, 4'hf);
    s0 = shoot;
    for (int i = 3; i < 5; i++)
      wb_io(8'h68, 1'b1, {24'h0, offs[i]}, 4'hf);
    wb_io(8'h68, 1'b1, 32'h107, 4'hf);
    wb_io(8'h68, 1'b0, 32'h0, 4'hf);
    check(rd, 32'h107);
    wb_io(8'h68, 1'b1, 32'h0, 4'h2);
    wb_io(8'h68, 1'b0, 32'h0, 4'hf);
    check(rd, 32'h7);
    do @(negedge clock_i); while (pstart !== 1'b1);
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (pstart !== 1'b1);
    check(32'(n), 32'd10);
    // unequal duties so the common-mode shift is not zero: 4 - (8 + 2) / 2 = -1
    duty <= 36'h002004008;
    wb_io(8'h68, 1'b1, 32'h006, 4'hf);
    repeat (12) @(posedge clock_i);
    width(n);
    check(32'(n), 32'd8);
    wb_io(8'h68, 1'b1, 32'h106, 4'hf);
    repeat (12) @(posedge clock_i);
    width(n);
    check(32'(n), 32'd7);
    repeat (40) @(posedge clock_i);
    check(32'(shoot - s0), 32'h0);
    conclude();
  end
endmodule : tb
